// ===== pswsc_core.sv
// Purpose: program space window, stall control, stack limit, modulo select
// Assumes: single clock, registers over apb, instruction stream decoded outside
// Notes: program memory answers a read in one cycle, writes take one cycle
//
// Summary of operation
// - upper 32k data window onto program pages
// - window enable redirects x accesses to program
// - window data access done within three cycles
// - read-after-write dependency still stalls one cycle
// - two extra cycles, one for mac/move
// - repeat loop steady iterations add nothing
// - loop edges and interrupt exits cost two
// - pointer over limit by two: no trap on a write
// - any stack pointer address use checked
// - select 1111 or enable bit low disables, else picks register
// - modulo control layout, bits 13:12 unused
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "pswsc_defines.svh"
`default_nettype none

module pswsc_core (
   input wire logic i_clk, // core clock, 250 mhz
   input wire logic i_srst, // synchronous reset, high
   input wire logic i_ce, // clock enable, freezes state when low
   // apb slave
   input wire logic i_psel, // apb select
   input wire logic i_penable, // apb access phase
   input wire logic i_pwrite, // apb write
   input wire logic [11:0] i_paddr, // apb byte address
   input wire logic [31:0] i_pwdata, // apb write data
   output logic o_pready, // apb ready
   output logic [31:0] o_prdata, // apb read data
   output logic o_pslverr, // apb error on unmapped address
   // instruction stream
   input wire logic i_x_req, // x space data access request
   input wire logic i_x_write, // access is a write
   input wire logic [15:0] i_x_ea, // x space effective address
   input wire logic [15:0] i_x_wdata, // write data
   input wire pswsc_pkg::pswsc_class_t i_x_class, // instruction class
   input wire logic i_raw_dep, // read-after-write dependency seen
   input wire logic i_in_repeat, // inside a hardware repeat loop
   input wire logic i_rep_edge, // first, last or interrupt exit/re-entry
   input wire logic i_sp_use, // instruction forms ea from stack pointer
   input wire logic [15:0] i_stack_pointer, // stack pointer value
   output logic o_x_done, // data access complete
   output logic [15:0] o_x_rdata, // read data
   output logic o_stall, // hold instruction issue
   output logic o_prefetch_hold, // suspend instruction prefetch
   output logic o_stack_trap, // stack error trap pulse
   output logic [14:0] o_x_mod_onehot, // x modulo register select
   output logic [14:0] o_y_mod_onehot, // y modulo register select
   output logic o_irq, // level interrupt
   // program memory bus
   output logic o_pm_req, // program bus request
   output logic o_pm_write, // program bus write
   output logic [22:0] o_pm_addr, // program word address
   output logic [15:0] o_pm_wdata, // program bus write data
   input wire logic [15:0] i_pm_rdata // program bus read data
);
   import pswsc_pkg::*;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [15:0] modctl_reg; // modulo control
   logic [15:0] core_reg; // core control
   logic [7:0] page_reg; // window page
   logic [15:0] stack_limit_register_reg; // stack limit
   logic [2:0] stat_reg; // sticky events
   logic [2:0] mask_reg; // interrupt mask
   logic [2:0] ev_set; // event pulses
   pswsc_state_t state_reg; // fetch sequencer
   logic [1:0] cnt_reg; // extra cycles left
   logic [1:0] extra_need; // extra cycles for this access
   logic raw_reg; // pending dependency stall
   logic win_hit; // access inside window
   logic apb_wr; // apb write strobe
   logic apb_rd; // apb read strobe
   logic hit; // address mapped

   // decode one 4-bit select to a one-hot register pick
   function automatic logic [14:0] sel_decode(input logic [3:0] sel, input logic en);
      logic [14:0] r;
      r = 15'h0000;
      // all-ones disables
      // enable low selects no register either
      if (en && sel != `PSWSC_SEL_OFF) begin
         r[sel] = 1'b1;
      end
      return r;
   endfunction

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // write lands in the access phase only
   assign apb_wr = i_ce & i_psel & i_penable & i_pwrite;
   // read qualifier, setup phase picked below
   assign apb_rd = i_psel & ~i_pwrite;
   // no wait states: every register is a flop
   assign o_pready = 1'b1;
   // unmapped offsets answer with an error
   assign hit = i_paddr == `PSWSC_OFF_MODCTL || i_paddr == `PSWSC_OFF_CORE ||
                i_paddr == `PSWSC_OFF_PAGE || i_paddr == `PSWSC_OFF_STACK_LIMIT_REGISTER ||
                i_paddr == `PSWSC_OFF_STAT || i_paddr == `PSWSC_OFF_MASK ||
                i_paddr == `PSWSC_OFF_MODSEL;
   assign o_pslverr = i_psel & i_penable & ~hit;

   // read mux, registered at setup so data is ready in access phase
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_ce && apb_rd && !i_penable) begin
         if (i_paddr == `PSWSC_OFF_MODCTL) begin
            // unused bits are already zero in the flop
            o_prdata <= {16'h0000, modctl_reg};
         end else if (i_paddr == `PSWSC_OFF_CORE) begin
            // core control word
            o_prdata <= {16'h0000, core_reg};
         end else if (i_paddr == `PSWSC_OFF_PAGE) begin
            // window page, eight bits
            o_prdata <= {24'h000000, page_reg};
         end else if (i_paddr == `PSWSC_OFF_STACK_LIMIT_REGISTER) begin
            // stack limit word
            o_prdata <= {16'h0000, stack_limit_register_reg};
         end else if (i_paddr == `PSWSC_OFF_STAT) begin
            // sticky event bits
            o_prdata <= {29'h0000_0000, stat_reg};
         end else if (i_paddr == `PSWSC_OFF_MASK) begin
            // interrupt mask bits
            o_prdata <= {29'h0000_0000, mask_reg};
         end else if (i_paddr == `PSWSC_OFF_MODSEL) begin
            // decoded y select, for software to see
            o_prdata <= {2'h0, o_y_mod_onehot, 15'h0000};
         end else begin
            // unmapped: zero with the error flag
            o_prdata <= 32'h0000_0000;
         end
      end
   end

   // modulo control register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         modctl_reg <= `PSWSC_MOD_RST;
      end else if (apb_wr && i_paddr == `PSWSC_OFF_MODCTL) begin
         modctl_reg <= i_pwdata[15:0] & `PSWSC_MOD_WMASK;
      end
   end

   // core control, page and limit registers
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         core_reg <= `PSWSC_CORE_RST;
         page_reg <= 8'h00;
         stack_limit_register_reg <= 16'h0000;
         mask_reg <= 3'h0;
      end else if (apb_wr) begin
         if (i_paddr == `PSWSC_OFF_CORE) begin
            // bit 2 opens the program window
            core_reg <= i_pwdata[15:0];
         end else if (i_paddr == `PSWSC_OFF_PAGE) begin
            // upper program address bits
            page_reg <= i_pwdata[7:0];
         end else if (i_paddr == `PSWSC_OFF_STACK_LIMIT_REGISTER) begin
            // limit compared against the pointer
            stack_limit_register_reg <= i_pwdata[15:0];
         end else if (i_paddr == `PSWSC_OFF_MASK) begin
            // one enable per status bit
            mask_reg <= i_pwdata[2:0];
         end
      end
   end

   // ----------------------------------------
   // interrupt status
   // ----------------------------------------
   // sticky bits, set beats write-one-to-clear
   // an event in the clearing cycle survives the clear
   // only the bits written as one are cleared
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         stat_reg <= 3'h0;
      end else if (i_ce) begin
         if (apb_wr && i_paddr == `PSWSC_OFF_STAT) begin
            stat_reg <= (stat_reg & ~i_pwdata[2:0]) | ev_set;
         end else begin
            stat_reg <= stat_reg | ev_set;
         end
      end
   end

   assign o_irq = |(stat_reg & mask_reg);

   // ----------------------------------------
   // modulo register selection
   // ----------------------------------------
   // decode both selects
   assign o_x_mod_onehot = sel_decode(modctl_reg[3:0], modctl_reg[`PSWSC_MOD_XEN]);
   assign o_y_mod_onehot = sel_decode(modctl_reg[7:4], modctl_reg[`PSWSC_MOD_YEN]);

   // ----------------------------------------
   // stack limit check
   // ----------------------------------------
   // trap once pointer passes limit+2
   // a push landing exactly at limit+2 is let through
   // a stack use that is not a write at limit+2 already traps
   // the pulse is one cycle behind the stack use
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_stack_trap <= 1'b0;
      end else if (i_ce) begin
         o_stack_trap <= i_sp_use && (i_stack_pointer > stack_limit_register_reg + `PSWSC_STK_MARGIN ||
                         (i_stack_pointer == stack_limit_register_reg + `PSWSC_STK_MARGIN && !i_x_write));
      end
   end

   // ----------------------------------------
   // window fetch sequencer
   // ----------------------------------------
   // window hit when enabled and in upper half
   assign win_hit = core_reg[`PSWSC_CORE_WIN] && i_x_ea >= `PSWSC_WIN_BASE;

   // extra cycle count for this access
   always_comb begin
      // steady repeat iterations overlap the fetch
      if (i_in_repeat && !i_rep_edge) begin
         extra_need = 2'h0;
      end else if (i_in_repeat) begin
         extra_need = `PSWSC_LOOP_EDGE;
      end else if (i_x_class != PSWSC_CLS_OTHER) begin
         extra_need = `PSWSC_EXTRA_FAST;
      end else begin
         extra_need = `PSWSC_EXTRA_FULL;
      end
   end

   // sequencer state and counter
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_reg <= PSWSC_IDLE;
         cnt_reg <= 2'h0;
      end else if (i_ce) begin
         case (state_reg)
            PSWSC_IDLE: begin
               // wait for a window hit
               if (i_x_req && win_hit) begin
                  cnt_reg <= extra_need;
                  state_reg <= (extra_need == 2'h0) ? PSWSC_DONE : PSWSC_FETCH;
               end
            end
            PSWSC_FETCH: begin
               cnt_reg <= cnt_reg - 2'h1;
               state_reg <= (cnt_reg <= 2'h1) ? PSWSC_DONE : PSWSC_WAIT;
            end
            PSWSC_WAIT: begin
               // second extra cycle of a full fetch
               cnt_reg <= cnt_reg - 2'h1;
               state_reg <= PSWSC_DONE;
            end
            PSWSC_DONE: begin
               // completion stands one cycle
               state_reg <= PSWSC_IDLE;
            end
            default: begin
               // stray code: back to idle
               state_reg <= PSWSC_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // timing of one window access
   // ----------------------------------------
   // take edge: idle, request and window hit
   // same edge launches the program bus request
   // memory answers in the request cycle
   // read word captured at the end of it
   // full class: fetch, wait, then done
   // fast class: fetch, then done
   // steady repeat: straight to done
   // loop edge: same cost as the full class
   // done stands for exactly one cycle
   // requester drops its request at done
   // else a new access starts at once
   // hazard: a slower memory breaks the fast path
   // steady repeat data lands just after done

   // program bus drive and read capture
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_pm_req <= 1'b0;
         o_pm_write <= 1'b0;
         o_pm_addr <= 23'h000000;
         o_pm_wdata <= 16'h0000;
         o_x_rdata <= 16'h0000;
      end else if (i_ce) begin
         // launch on the take edge, one cycle only
         if (state_reg == PSWSC_IDLE && i_x_req && win_hit) begin
            o_pm_req <= 1'b1;
            o_pm_write <= i_x_write;
            o_pm_addr <= {page_reg, i_x_ea[14:0]};
            o_pm_wdata <= i_x_wdata;
         end else begin
            o_pm_req <= 1'b0;
         end
         // memory answers while the request stands
         if (o_pm_req && !o_pm_write) begin
            o_x_rdata <= i_pm_rdata;
         end
      end
   end

   // dependency stall, one cycle per flagged instruction
   // a flag seen while stalling is absorbed by that stall
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         raw_reg <= 1'b0;
      end else if (i_ce) begin
         raw_reg <= i_raw_dep && !raw_reg;
      end
   end

   assign o_x_done = state_reg == PSWSC_DONE;
   // hold issue and prefetch during fetch
   assign o_prefetch_hold = state_reg == PSWSC_FETCH || state_reg == PSWSC_WAIT ||
                            (state_reg == PSWSC_IDLE && i_x_req && win_hit);
   assign o_stall = o_prefetch_hold || raw_reg;

   // event pulses into status
   // bit order: dependency, window done, stack trap
   assign ev_set = {raw_reg, o_x_done, o_stack_trap};

endmodule

`default_nettype wire

// ===== pswsc_defines.svh
// Purpose: offsets, field positions, reset values and cycle counts
// Assumes: included by the testbench and the design file
// Notes: byte addresses on a 32-bit apb bus
`ifndef PSWSC_DEFINES_SVH
`define PSWSC_DEFINES_SVH

// register byte offsets
`define PSWSC_OFF_MODCTL 12'h000
`define PSWSC_OFF_CORE 12'h004
`define PSWSC_OFF_PAGE 12'h008
`define PSWSC_OFF_STACK_LIMIT_REGISTER 12'h00c
`define PSWSC_OFF_STAT 12'h010
`define PSWSC_OFF_MASK 12'h014
`define PSWSC_OFF_MODSEL 12'h018

// modulo control fields
`define PSWSC_MOD_XEN 15
`define PSWSC_MOD_YEN 14
`define PSWSC_MOD_WMASK 16'hcfff
`define PSWSC_MOD_RST 16'h0000
`define PSWSC_SEL_OFF 4'hf

// core control window enable bit
`define PSWSC_CORE_WIN 2
`define PSWSC_CORE_RST 16'h0000

// status bits
`define PSWSC_ST_STKERR 0
`define PSWSC_ST_WINACC 1
`define PSWSC_ST_RAW 2

// window geometry: upper 32 kbytes of data space
`define PSWSC_WIN_BASE 16'h8000
`define PSWSC_STK_MARGIN 16'h0002

// extra cycles per window access
`define PSWSC_EXTRA_FULL 2'h2
`define PSWSC_EXTRA_FAST 2'h1
`define PSWSC_LOOP_EDGE 2'h2
`define PSWSC_MAX_CYC 2'h3

`endif

// ===== pswsc_pkg.sv
// Purpose: shared types for the window and stall controller
// Assumes: nothing
// Notes: one-hot state encoding
package pswsc_pkg;
   // operand fetch sequencer
   typedef enum logic [3:0] {
      PSWSC_IDLE = 4'h1,
      PSWSC_FETCH = 4'h2,
      PSWSC_WAIT = 4'h4,
      PSWSC_DONE = 4'h8
   } pswsc_state_t;
   // instruction class of a window access
   typedef enum logic [1:0] {
      PSWSC_CLS_OTHER = 2'h0,
      PSWSC_CLS_MAC = 2'h1,
      PSWSC_CLS_MOVE = 2'h2
   } pswsc_class_t;
endpackage

// ===== pswsc_core_monitor.sv
// Purpose: port checker for the window and stall controller
// Assumes: one clock, synchronous reset high
// Notes: bound onto pswsc_core at the foot
`timescale 1ns/1ps
`default_nettype none
module pswsc_core_monitor (
   input wire logic i_clk, // core clock
   input wire logic i_srst, // sync reset
   input wire logic [15:0] i_x_ea, // data address
   input wire logic [15:0] i_x_wdata, // data to write
   input wire pswsc_pkg::pswsc_class_t i_x_class, // instruction class
   input wire logic i_in_repeat, // inside loop
   input wire logic i_rep_edge, // loop edge iteration
   input wire logic i_sp_use, // stack pointer used
   input wire logic o_x_done, // access complete
   input wire logic o_stall, // issue hold
   input wire logic o_prefetch_hold, // prefetch hold
   input wire logic o_stack_trap, // trap pulse
   input wire logic [14:0] o_x_mod_onehot, // x select
   input wire logic [14:0] o_y_mod_onehot, // y select
   input wire logic o_pm_req, // bus request
   input wire logic o_pm_write, // bus write
   input wire logic [22:0] o_pm_addr, // bus address
   input wire logic [15:0] o_pm_wdata // bus write data
);
   import pswsc_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   property p_full;
      o_pm_req && i_x_class == PSWSC_CLS_OTHER && !i_in_repeat |-> ##1 !o_x_done ##1 o_x_done;
   endproperty
   a_full: assert property (p_full) else $error("full fetch time wrong");
   property p_fast;
      o_pm_req && i_x_class != PSWSC_CLS_OTHER && !i_in_repeat |-> ##1 o_x_done;
   endproperty
   a_fast: assert property (p_fast) else $error("short fetch time wrong");
   property p_edge;
      o_pm_req && i_in_repeat && i_rep_edge |-> ##1 !o_x_done ##1 o_x_done;
   endproperty
   a_edge: assert property (p_edge) else $error("loop edge time wrong");
   property p_bound;
      $rose(o_pm_req) |-> ##[0:2] o_x_done;
   endproperty
   a_bound: assert property (p_bound) else $error("window access too slow");
   // steady repeat iterations hold issue only in the take cycle, so their request cycle is done
   property p_hold;
      o_pm_req && !o_x_done |-> o_stall && o_prefetch_hold;
   endproperty
   a_hold: assert property (p_hold) else $error("issue not held in fetch");
   property p_addr;
      o_pm_req |-> o_pm_addr[14:0] == i_x_ea[14:0];
   endproperty
   a_addr: assert property (p_addr) else $error("program address wrong");
   property p_wdata;
      o_pm_req && o_pm_write |-> o_pm_wdata == i_x_wdata;
   endproperty
   a_wdata: assert property (p_wdata) else $error("program write data wrong");
   property p_trap;
      o_stack_trap |-> $past(i_sp_use);
   endproperty
   a_trap: assert property (p_trap) else $error("trap without stack use");
   property p_sel;
      $onehot0(o_x_mod_onehot) && $onehot0(o_y_mod_onehot);
   endproperty
   a_sel: assert property (p_sel) else $error("modulo select not one hot");
endmodule
bind pswsc_core pswsc_core_monitor u_mon (.i_clk(i_clk), .i_srst(i_srst), .i_x_ea(i_x_ea),
   .i_x_wdata(i_x_wdata), .i_x_class(i_x_class), .i_in_repeat(i_in_repeat),
   .i_rep_edge(i_rep_edge), .i_sp_use(i_sp_use), .o_x_done(o_x_done), .o_stall(o_stall),
   .o_prefetch_hold(o_prefetch_hold), .o_stack_trap(o_stack_trap),
   .o_x_mod_onehot(o_x_mod_onehot), .o_y_mod_onehot(o_y_mod_onehot), .o_pm_req(o_pm_req),
   .o_pm_write(o_pm_write), .o_pm_addr(o_pm_addr), .o_pm_wdata(o_pm_wdata));
`default_nettype wire

// ===== pswsc_pm_model.sv
// Purpose: program memory on the far side of the program bus
// Assumes: read data stands in the cycle that carries the request
// Notes: unwritten words read as address xor 5a5a; 256 words, low address bits
`timescale 1ns/1ps
`default_nettype none
module pswsc_pm_model (
   input wire logic i_clk, // core clock
   input wire logic i_req, // bus request
   input wire logic i_write, // write cycle
   input wire logic [22:0] i_addr, // word address
   input wire logic [15:0] i_wdata, // write data
   output logic [15:0] o_rdata // read data
);
   logic [15:0] mem [0:255]; // written words
   logic [255:0] used = '0; // word written flags
   logic [15:0] last_q = 16'h0000; // value shown last cycle
   // read answers in the request cycle, otherwise inverse of last value
   always_comb begin
      if (i_req && !i_write) begin
         o_rdata = used[i_addr[7:0]] ? mem[i_addr[7:0]] : (i_addr[15:0] ^ 16'h5a5a);
      end else begin
         o_rdata = ~last_q;
      end
   end
   // writes land at the edge that ends the request cycle
   always_ff @(posedge i_clk) begin
      if (i_req && i_write) begin
         mem[i_addr[7:0]] <= i_wdata;
         used[i_addr[7:0]] <= 1'b1;
      end
      last_q <= o_rdata;
   end
endmodule
`default_nettype wire

// ===== program_space_window_and_stall_control_tb.sv
// Purpose: self-checking bench for pswsc_core
// Assumes: apb master tasks, program memory model
// Notes: latency 7 in win() means the access is ignored
`timescale 1ns/1ps
`default_nettype none
`include "pswsc_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module program_space_window_and_stall_control_tb;
   import pswsc_pkg::*;
   logic i_clk = 0, i_srst = 1, psel = 0, pen = 0, pwr = 0, pready, pslverr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic xreq = 0, xwr = 0, raw = 0, inrep = 0, redge = 0, spu = 0, done, stall, pfh;
   logic trap, irq, pmreq, pmwr;
   logic ce = 1; // clock enable
   logic [15:0] ea = 0, xwd = 0, sp = 0, pmr, xrd, pmwd;
   logic [14:0] xoh, yoh;
   logic [22:0] pma;
   pswsc_class_t cls = PSWSC_CLS_OTHER;
   int miscompares = 0, samples_checked = 0;
   always #2 i_clk = ~i_clk;
   pswsc_core dut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(ce), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_x_req(xreq), .i_x_write(xwr), .i_x_ea(ea),
      .i_x_wdata(xwd), .i_x_class(cls), .i_raw_dep(raw), .i_in_repeat(inrep),
      .i_rep_edge(redge), .i_sp_use(spu), .i_stack_pointer(sp), .o_x_done(done),
      .o_x_rdata(xrd), .o_stall(stall), .o_prefetch_hold(pfh), .o_stack_trap(trap),
      .o_x_mod_onehot(xoh), .o_y_mod_onehot(yoh), .o_irq(irq), .o_pm_req(pmreq),
      .o_pm_write(pmwr), .o_pm_addr(pma), .o_pm_wdata(pmwd), .i_pm_rdata(pmr));
   pswsc_pm_model pm (.i_clk(i_clk), .i_req(pmreq), .i_write(pmwr), .i_addr(pma),
      .i_wdata(pmwd), .o_rdata(pmr));
   // counts, verdict and stop
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      @(posedge i_clk);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      pen <= 1;
      n = 0;
      // access phase lasts until pready is seen high at an edge
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1 && n < 8);
      if (pready !== 1'b1) begin
         miscompares++;
         end_of_test();
      end
      r = prdata;
      e = pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(0, a, 0, r, e);
      `CHK(r, x)
   endtask
   // window access: latency counted in edges after the take edge
   task automatic win(input logic w, input logic [15:0] a, input pswsc_class_t c,
      input logic rp, input logic ed, input int lat, input logic [15:0] x);
      int n;
      @(posedge i_clk);
      xreq <= 1;
      xwr <= w;
      ea <= a;
      cls <= c;
      inrep <= rp;
      redge <= ed;
      xwd <= x;
      for (n = 1; n < 8; n++) begin
         @(posedge i_clk);
         if (done === 1'b1) break;
      end
      xreq <= 0;
      `CHK(n - 1, lat)
      if (!w && lat > 1 && lat < 7) `CHK(xrd, x)
   endtask
   // stack pointer use, trap looked at one cycle later
   task automatic stk(input logic w, input logic [15:0] s, input logic t);
      @(posedge i_clk);
      spu <= 1;
      xwr <= w;
      sp <= s;
      @(posedge i_clk);
      spu <= 0;
      @(posedge i_clk);
      `CHK(trap, t)
   endtask
   initial begin
      logic [31:0] r;
      logic e;
      logic [14:0] x;
      repeat (4) @(posedge i_clk);
      i_srst <= 0;
      rd(`PSWSC_OFF_MODCTL, 32'h0);
      wr(`PSWSC_OFF_MODCTL, 32'hffff);
      rd(`PSWSC_OFF_MODCTL, 32'hcfff);
      apb(0, 12'h01c, 32'h0, r, e);
      `CHK({e, r}, 33'h100000000)
      for (int i = 0; i < 16; i++) begin
         // both modulo enables set, same select on x and y
         wr(`PSWSC_OFF_MODCTL, {16'h0000, 8'hc0, i[3:0], i[3:0]});
         x = (i == 15) ? 15'h0 : 15'h1 << i;
         // no x read in the cycle after a modulo write
         @(posedge i_clk);
         `CHK({xoh, yoh}, {x, x})
         rd(`PSWSC_OFF_MODSEL, {2'h0, x, 15'h0});
      end
      // clock enable low: the write must not land
      ce <= 0;
      wr(`PSWSC_OFF_MODCTL, 32'h0);
      ce <= 1;
      rd(`PSWSC_OFF_MODCTL, 32'hc0ff);
      $display("test registers and selects done");
      wr(`PSWSC_OFF_PAGE, 32'haa);
      win(0, 16'h8123, PSWSC_CLS_OTHER, 0, 0, 7, 16'h0);
      wr(`PSWSC_OFF_CORE, 32'h4);
      win(0, 16'h7ffe, PSWSC_CLS_OTHER, 0, 0, 7, 16'h0);
      win(0, 16'h8123, PSWSC_CLS_OTHER, 0, 0, 3, 16'h5b79);
      win(0, 16'h8124, PSWSC_CLS_MAC, 0, 0, 2, 16'h5b7e);
      win(1, 16'hfffe, PSWSC_CLS_MOVE, 0, 0, 2, 16'hbeef);
      win(0, 16'hfffe, PSWSC_CLS_MOVE, 0, 0, 2, 16'hbeef);
      win(0, 16'h8123, PSWSC_CLS_OTHER, 1, 1, 3, 16'h5b79);
      win(0, 16'h8123, PSWSC_CLS_OTHER, 1, 0, 1, 16'h5b79);
      win(0, 16'h8123, PSWSC_CLS_MAC, 1, 1, 3, 16'h5b79);
      $display("test window done");
      wr(`PSWSC_OFF_STACK_LIMIT_REGISTER, 32'h1000);
      stk(1, 16'h1002, 0);
      stk(1, 16'h1004, 1);
      stk(0, 16'h1002, 1);
      stk(0, 16'h1000, 0);
      // one dependency flag gives exactly one stall cycle
      @(posedge i_clk);
      raw <= 1;
      @(posedge i_clk);
      raw <= 0;
      @(posedge i_clk);
      `CHK(stall, 1'b1)
      @(posedge i_clk);
      `CHK(stall, 1'b0)
      rd(`PSWSC_OFF_STAT, 32'h7);
      wr(`PSWSC_OFF_MASK, 32'h0);
      @(posedge i_clk);
      `CHK(irq, 1'b0)
      wr(`PSWSC_OFF_MASK, 32'h1);
      @(posedge i_clk);
      `CHK(irq, 1'b1)
      wr(`PSWSC_OFF_STAT, 32'h1);
      rd(`PSWSC_OFF_STAT, 32'h6);
      `CHK(irq, 1'b0)
      $display("test stack and interrupt done");
      end_of_test();
   end
endmodule
`default_nettype wire
